// ---- src/mcs_sequencer.v ----
// measurement scheduling and output status of the sensor core
`include "mcs_consts.vh"
`default_nettype none

module mcs_sequencer #(
   parameter TW = 24,
   parameter OSC_PCT = `MCS_OSC_PCT,
   parameter UPD_1M_R0 = `MCS_UPD_1M_R0_US * `MCS_CYC_PER_US,
   parameter UPD_1M_R1 = `MCS_UPD_1M_R1_US * `MCS_CYC_PER_US,
   parameter UPD_1M_R2 = `MCS_UPD_1M_R2_US * `MCS_CYC_PER_US,
   parameter UPD_1M_R3 = `MCS_UPD_1M_R3_US * `MCS_CYC_PER_US,
   parameter UPD_4M_R0 = `MCS_UPD_4M_R0_US * `MCS_CYC_PER_US,
   parameter UPD_4M_R1 = `MCS_UPD_4M_R1_US * `MCS_CYC_PER_US,
   parameter UPD_4M_R2 = `MCS_UPD_4M_R2_US * `MCS_CYC_PER_US,
   parameter UPD_4M_R3 = `MCS_UPD_4M_R3_US * `MCS_CYC_PER_US,
   parameter SLP_RD_1M = `MCS_SLP_RD_1M_US * `MCS_CYC_PER_US,
   parameter SLP_WR_1M = `MCS_SLP_WR_1M_US * `MCS_CYC_PER_US,
   parameter SLP_RD_4M = `MCS_SLP_RD_4M_US * `MCS_CYC_PER_US,
   parameter SLP_WR_4M = `MCS_SLP_WR_4M_US * `MCS_CYC_PER_US,
   parameter SLP_RD_1M_LONG = `MCS_SLP_RD_1M_LONG_US * `MCS_CYC_PER_US,
   parameter SLP_WR_1M_LONG = `MCS_SLP_WR_1M_LONG_US * `MCS_CYC_PER_US,
   parameter SLP_RD_4M_LONG = `MCS_SLP_RD_4M_LONG_US * `MCS_CYC_PER_US,
   parameter SLP_WR_4M_LONG = `MCS_SLP_WR_4M_LONG_US * `MCS_CYC_PER_US,
   parameter STARTUP_CYC = `MCS_T_STARTUP_US * `MCS_CYC_PER_US,
   parameter WIN_LOCKED_CYC = `MCS_T_WIN_LOCKED_US * `MCS_CYC_PER_US,
   parameter WIN_EXTRA_CYC = `MCS_T_WIN_EXTRA_US * `MCS_CYC_PER_US
) (
   input wire clk,
   input wire sys_rst,
   input wire sleep_mode,
   input wire i2c_sel,
   input wire core_fast,
   input wire long_integration,
   input wire mem_locked,
   input wire [1:0] update_rate,
   input wire measure_request_read,
   input wire measure_request_write,
   input wire result_fetch_read,
   input wire diag_fault,
   input wire [13:0] bridge_code,
   input wire [10:0] temp_code,
   input wire int_ss_in,
   output reg int_ss_out,
   output wire int_ss_oe,
   output reg [1:0] out_status,
   output reg [13:0] out_bridge,
   output reg [10:0] out_temp,
   output reg [1:0] conv_phase,
   output wire powered_down,
   output reg result_written
);

   localparam ST_START = 2'h0;
   localparam ST_SLEEP = 2'h1;
   localparam ST_MEAS = 2'h2;
   localparam ST_DOWN = 2'h3;

   localparam PH_NONE = 2'h0;
   localparam PH_TEMP = 2'h1;
   localparam PH_ZERO = 2'h2;
   localparam PH_BRIDGE = 2'h3;

   localparam SS_LOW_CYC = `MCS_T_SS_LOW_US * `MCS_CYC_PER_US;
   localparam [9:0] SS_LOW_MAX = SS_LOW_CYC;

   // typical figures, trimmed by oscillator percent
   function [TW-1:0] scale;
      input integer cyc;
      integer s;
      begin
         s = cyc * OSC_PCT / 100;
         if (s < 1) begin
            s = 1;
         end
         scale = s[TW-1:0];
      end
   endfunction

   // update period per rate and clock
   function [TW-1:0] upd_period;
      input fast;
      input [1:0] rsel;
      begin
         case ({fast, rsel})
            3'h0: upd_period = scale(UPD_1M_R0);
            3'h1: upd_period = scale(UPD_1M_R1);
            3'h2: upd_period = scale(UPD_1M_R2);
            3'h3: upd_period = scale(UPD_1M_R3);
            3'h4: upd_period = scale(UPD_4M_R0);
            3'h5: upd_period = scale(UPD_4M_R1);
            3'h6: upd_period = scale(UPD_4M_R2);
            default: upd_period = scale(UPD_4M_R3);
         endcase
      end
   endfunction

   function [TW-1:0] bridge_time;
      input fast;
      input lng;
      begin
         case ({fast, lng})
            2'h0: bridge_time = scale(SLP_WR_1M);
            2'h1: bridge_time = scale(SLP_WR_1M_LONG);
            2'h2: bridge_time = scale(SLP_WR_4M);
            default: bridge_time = scale(SLP_WR_4M_LONG);
         endcase
      end
   endfunction

   // read response minus bridge, split over two specials
   function [TW-1:0] special_time;
      input fast;
      input lng;
      begin
         case ({fast, lng})
            2'h0: special_time = scale((SLP_RD_1M - SLP_WR_1M) / 2);
            2'h1: special_time = scale((SLP_RD_1M_LONG - SLP_WR_1M_LONG) / 2);
            2'h2: special_time = scale((SLP_RD_4M - SLP_WR_4M) / 2);
            default: special_time = scale((SLP_RD_4M_LONG - SLP_WR_4M_LONG) / 2);
         endcase
      end
   endfunction

   function [7:0] spec_interval;
      input [1:0] rsel;
      begin
         case (rsel)
            2'h0: spec_interval = `MCS_SPEC_R0;
            2'h1: spec_interval = `MCS_SPEC_R1;
            2'h2: spec_interval = `MCS_SPEC_R2;
            default: spec_interval = `MCS_SPEC_R3;
         endcase
      end
   endfunction

   reg [1:0] state;
   reg [TW-1:0] timer;
   reg [1:0] rate;
   reg full_seq;
   reg spec_zero;
   reg [7:0] spec_cnt;
   reg [10:0] temp_hold;
   reg fault;
   reg ss_meta;
   reg ss_sync;
   reg ss_prev;
   reg [9:0] ss_low_cnt;

   wire [TW-1:0] startup_len = scale(STARTUP_CYC);
   wire [TW-1:0] elapsed = timer;
   // command window longer while memory unlocked
   wire [TW-1:0] window_len = mem_locked ? scale(WIN_LOCKED_CYC) :
                              scale(WIN_LOCKED_CYC + WIN_EXTRA_CYC);
   wire in_window = elapsed < window_len;

   wire [TW-1:0] conv_len = bridge_time(core_fast, long_integration);
   wire [TW-1:0] spec_len = special_time(core_fast, long_integration);
   wire [TW-1:0] period_len = upd_period(core_fast, rate);
   wire [TW-1:0] down_len = (period_len > conv_len) ? period_len - conv_len : {TW{1'b0}};
   wire [TW-1:0] one = {{(TW-1){1'b0}}, 1'b1};

   // spi wake needs the select low long enough before its rise
   wire ss_rise = ss_sync & ~ss_prev;
   wire spi_wake = ~i2c_sel & ss_rise & (ss_low_cnt >= SS_LOW_MAX);
   wire wake_read = (i2c_sel & measure_request_read) | spi_wake;
   // write-type request exists only on i2c
   wire wake_write = i2c_sel & measure_request_write;

   // pin drives ready only in i2c operation
   assign int_ss_oe = i2c_sel;
   // rate 00 stays awake through the remainder
   assign powered_down = (state == ST_SLEEP) || (state == ST_DOWN && rate != 2'h0);

   always @(posedge clk) begin
      if (sys_rst) begin
         ss_meta <= 1'b1;
         ss_sync <= 1'b1;
         ss_prev <= 1'b1;
         ss_low_cnt <= 10'h000;
      end else begin
         ss_meta <= int_ss_in;
         ss_sync <= ss_meta;
         ss_prev <= ss_sync;
         if (ss_sync) begin
            ss_low_cnt <= 10'h000;
         end else if (ss_low_cnt < SS_LOW_MAX) begin
            ss_low_cnt <= ss_low_cnt + 10'h001;
         end
      end
   end

   always @(posedge clk) begin
      if (sys_rst) begin
         state <= ST_START;
         timer <= {TW{1'b0}};
         // rate field starts at the factory code
         rate <= `MCS_RATE_DEFAULT;
         full_seq <= 1'b0;
         spec_zero <= 1'b0;
         spec_cnt <= 8'h00;
         temp_hold <= 11'h000;
         fault <= 1'b0;
         // no result yet, reads as stale
         out_status <= `MCS_ST_STALE;
         out_bridge <= 14'h0000;
         out_temp <= 11'h000;
         conv_phase <= PH_NONE;
         int_ss_out <= 1'b0;
         result_written <= 1'b0;
      end else begin
         result_written <= 1'b0;
         // a fetch of valid data makes it stale
         if (result_fetch_read && out_status == `MCS_ST_VALID) begin
            out_status <= `MCS_ST_STALE;
         end
         if (result_fetch_read) begin
            int_ss_out <= 1'b0;
         end
         case (state)
            ST_START: begin
               if (timer == startup_len - one) begin
                  rate <= update_rate;
                  out_status <= fault ? `MCS_ST_DIAG : `MCS_ST_STALE;
                  if (sleep_mode) begin
                     state <= ST_SLEEP;
                  end else begin
                     state <= ST_MEAS;
                     conv_phase <= PH_TEMP;
                     full_seq <= 1'b1;
                     timer <= spec_len - one;
                  end
               end else begin
                  timer <= timer + one;
                  // command code during the command window
                  if (!fault) begin
                     out_status <= in_window ? `MCS_ST_CMD : `MCS_ST_STALE;
                  end
               end
            end
            ST_SLEEP: begin
               // powered down until a request arrives
               if (wake_read) begin
                  state <= ST_MEAS;
                  conv_phase <= PH_TEMP;
                  full_seq <= 1'b1;
                  timer <= spec_len - one;
               end else if (wake_write) begin
                  state <= ST_MEAS;
                  conv_phase <= PH_BRIDGE;
                  full_seq <= 1'b0;
                  timer <= conv_len - one;
               end
               if ((wake_read || wake_write) && out_status != `MCS_ST_DIAG) begin
                  out_status <= `MCS_ST_STALE;
               end
            end
            ST_MEAS: begin
               if (timer != {TW{1'b0}}) begin
                  timer <= timer - one;
               end else begin
                  case (conv_phase)
                     PH_TEMP: begin
                        temp_hold <= temp_code;
                        conv_phase <= full_seq ? PH_ZERO : PH_BRIDGE;
                        timer <= full_seq ? spec_len - one : conv_len - one;
                     end
                     PH_ZERO: begin
                        conv_phase <= PH_BRIDGE;
                        timer <= conv_len - one;
                     end
                     default: begin
                        // result written once calculation is done
                        out_bridge <= bridge_code;
                        out_temp <= temp_hold;
                        result_written <= 1'b1;
                        // ready rises, and wins over a fetch
                        int_ss_out <= 1'b1;
                        // valid wins over a same-cycle fetch
                        if (fault || diag_fault) begin
                           fault <= 1'b1;
                           out_status <= `MCS_ST_DIAG;
                        end else begin
                           out_status <= `MCS_ST_VALID;
                        end
                        conv_phase <= PH_NONE;
                        full_seq <= 1'b0;
                        if (sleep_mode) begin
                           state <= ST_SLEEP;
                        end else begin
                           // rest of the period in ST_DOWN, powered down unless rate is 00
                           state <= ST_DOWN;
                           timer <= (down_len == {TW{1'b0}}) ? {TW{1'b0}} : down_len - one;
                        end
                     end
                  endcase
               end
            end
            default: begin
               if (timer != {TW{1'b0}}) begin
                  timer <= timer - one;
               end else begin
                  state <= ST_MEAS;
                  if (spec_cnt == spec_interval(rate)) begin
                     spec_cnt <= 8'h00;
                     spec_zero <= ~spec_zero;
                     conv_phase <= spec_zero ? PH_ZERO : PH_TEMP;
                     timer <= spec_len - one;
                  end else begin
                     spec_cnt <= spec_cnt + 8'h01;
                     conv_phase <= PH_BRIDGE;
                     timer <= conv_len - one;
                  end
               end
            end
         endcase
      end
   end

endmodule // mcs_sequencer

`default_nettype wire

// ---- shared/mcs_consts.vh ----
// constants for the measurement cycle sequencer
`ifndef MCS_CONSTS_VH
`define MCS_CONSTS_VH

// core timing base
`define MCS_CYC_PER_US 100
`define MCS_OSC_PCT 100

// update periods in microseconds, 1 MHz core clock
`define MCS_UPD_1M_R0_US 1600
`define MCS_UPD_1M_R1_US 5000
`define MCS_UPD_1M_R2_US 25000
`define MCS_UPD_1M_R3_US 125000
// update periods in microseconds, 4 MHz core clock
`define MCS_UPD_4M_R0_US 500
`define MCS_UPD_4M_R1_US 1500
`define MCS_UPD_4M_R2_US 6500
`define MCS_UPD_4M_R3_US 32000

// sleep response times in microseconds, normal integration
`define MCS_SLP_RD_1M_US 4500
`define MCS_SLP_WR_1M_US 1500
`define MCS_SLP_RD_4M_US 1500
`define MCS_SLP_WR_4M_US 500
// sleep response times in microseconds, long integration
`define MCS_SLP_RD_1M_LONG_US 12000
`define MCS_SLP_WR_1M_LONG_US 5500
`define MCS_SLP_RD_4M_LONG_US 4500
`define MCS_SLP_WR_4M_LONG_US 1500

// ordinary cycles between special measurements
`define MCS_SPEC_R0 8'hFF
`define MCS_SPEC_R1 8'h7F
`define MCS_SPEC_R2 8'h1F
`define MCS_SPEC_R3 8'h0F

// power-up and spi wake timing in microseconds
`define MCS_T_STARTUP_US 10000
`define MCS_T_WIN_LOCKED_US 1500
`define MCS_T_WIN_EXTRA_US 4500
`define MCS_T_SS_LOW_US 8

// status codes in the two top bits of the packet
`define MCS_ST_VALID 2'h0
`define MCS_ST_CMD 2'h1
`define MCS_ST_STALE 2'h2
`define MCS_ST_DIAG 2'h3

// reset value of the rate field
`define MCS_RATE_DEFAULT 2'h0

`endif

// ---- tb/mcs_seq_chk_asserts.sv ----
// port checker for the measurement cycle sequencer
`default_nettype none
module mcs_seq_chk (
   input wire logic clk,
   input wire logic sys_rst,
   input wire logic sleep_mode,
   input wire logic i2c_sel,
   input wire logic [1:0] update_rate,
   input wire logic result_fetch_read,
   input wire logic int_ss_out,
   input wire logic int_ss_oe,
   input wire logic [1:0] out_status,
   input wire logic [1:0] conv_phase,
   input wire logic powered_down,
   input wire logic result_written
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (sys_rst);
   chk_ready_on_result: assert property (result_written |-> int_ss_out)
      else $error("ready low after result");
   chk_result_valid: assert property (result_written |-> out_status != 2'h2)
      else $error("result not marked valid");
   // a write at the same edge wins over the fetch
   chk_fetch_stale: assert property (result_fetch_read && out_status == 2'h0
      |=> out_status == 2'h2 || result_written)
      else $error("fetch left status valid");
   chk_fetch_drops_ready: assert property (result_fetch_read |=> !int_ss_out || result_written)
      else $error("ready kept after fetch");
   chk_pin_drive: assert property (int_ss_oe == i2c_sel)
      else $error("pin drive wrong");
   chk_ready_rise: assert property ($rose(int_ss_out) |-> result_written)
      else $error("ready rose without result");
   chk_run_stale: assert property (sleep_mode && conv_phase != 2'h0 |-> out_status != 2'h0)
      else $error("valid during sleep run");
   chk_special_bridge: assert property ($past(conv_phase) == 2'h2 && conv_phase != 2'h2
      |-> conv_phase == 2'h3)
      else $error("no bridge after zero sample");
   chk_fault_hold: assert property (out_status == 2'h3 |=> out_status == 2'h3)
      else $error("fault status released");
   chk_fast_awake: assert property (!sleep_mode && update_rate == 2'h0 |-> !powered_down)
      else $error("power down at fastest rate");
   chk_down_idle: assert property (powered_down |-> conv_phase == 2'h0)
      else $error("converting while down");
endmodule // mcs_seq_chk
bind mcs_sequencer mcs_seq_chk u_chk (.clk(clk), .sys_rst(sys_rst), .sleep_mode(sleep_mode),
   .i2c_sel(i2c_sel), .update_rate(update_rate), .result_fetch_read(result_fetch_read),
   .int_ss_out(int_ss_out), .int_ss_oe(int_ss_oe), .out_status(out_status),
   .conv_phase(conv_phase), .powered_down(powered_down), .result_written(result_written));
`default_nettype wire

// ---- tb/mcs_host_model.sv ----
// host model issuing requests, fetches and the select pin
`default_nettype none
module mcs_host_model (
   input wire logic clk,
   input wire logic int_ss_out,
   input wire logic int_ss_oe,
   output logic measure_request_read,
   output logic measure_request_write,
   output logic result_fetch_read,
   output wire logic int_ss_in
);
   timeunit 1ns;
   timeprecision 1ps;
   logic ss_drv;
   initial begin
      ss_drv = 1'b1;
      {measure_request_read, measure_request_write, result_fetch_read} = 3'h0;
   end
   // pin level from whichever side drives it; select idles high
   assign int_ss_in = int_ss_oe ? int_ss_out : ss_drv;
   // one pulse per call, caller spaces them
   task automatic pulse(input int kind);
      @(negedge clk);
      case (kind)
         0: measure_request_read = 1'b1;
         1: measure_request_write = 1'b1;
         default: result_fetch_read = 1'b1;
      endcase
      @(negedge clk);
      {measure_request_read, measure_request_write, result_fetch_read} = 3'h0;
   endtask
   // select low stretch, rise wakes the device
   task automatic spi_wake(input int cyc);
      @(negedge clk);
      ss_drv = 1'b0;
      repeat (cyc) @(negedge clk);
      ss_drv = 1'b1;
   endtask
endmodule // mcs_host_model
`default_nettype wire

// ---- tb/mcs_sequencer_tb_top.sv ----
// self-checking bench for the measurement cycle sequencer
`default_nettype none
module mcs_sequencer_tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   logic clk, sys_rst, sleep_mode, i2c_sel, mem_locked, diag_fault, pd_seen;
   logic req_rd, req_wr, fetch, ss_out, ss_oe, written, pd;
   logic core_fast, long_integration;
   wire logic ss_in;
   logic [1:0] update_rate, status, phase;
   logic [13:0] bridge_code, o_bridge;
   logic [10:0] temp_code, o_temp;
   int num_errors = 0;
   int cmp_count = 0;
   int n, k;
   // shortened counts keep the run brief
   mcs_sequencer #(.STARTUP_CYC(200), .WIN_LOCKED_CYC(40), .WIN_EXTRA_CYC(60), .UPD_4M_R0(50),
      .UPD_4M_R1(60), .UPD_4M_R2(80), .UPD_4M_R3(100), .SLP_RD_4M(60), .SLP_WR_4M(20),
      .SLP_WR_1M(30), .SLP_WR_4M_LONG(40)) DUT (
      .clk(clk), .sys_rst(sys_rst), .sleep_mode(sleep_mode), .i2c_sel(i2c_sel),
      .core_fast(core_fast), .long_integration(long_integration), .mem_locked(mem_locked),
      .update_rate(update_rate), .measure_request_read(req_rd), .measure_request_write(req_wr),
      .result_fetch_read(fetch), .diag_fault(diag_fault), .bridge_code(bridge_code),
      .temp_code(temp_code), .int_ss_in(ss_in), .int_ss_out(ss_out), .int_ss_oe(ss_oe),
      .out_status(status), .out_bridge(o_bridge), .out_temp(o_temp), .conv_phase(phase),
      .powered_down(pd), .result_written(written));
   mcs_host_model host (.clk(clk), .int_ss_out(ss_out), .int_ss_oe(ss_oe),
      .measure_request_read(req_rd), .measure_request_write(req_wr),
      .result_fetch_read(fetch), .int_ss_in(ss_in));
   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end
   task automatic check(input logic [15:0] got, input logic [15:0] exp);
      cmp_count++;
      if (got !== exp) begin
         num_errors++;
         $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic settle(input int cyc);
      repeat (cyc) @(negedge clk);
   endtask
   task automatic do_reset(input logic sm, input logic ic, input logic lk, input logic [1:0] rt);
      @(negedge clk);
      sleep_mode = sm;
      i2c_sel = ic;
      mem_locked = lk;
      update_rate = rt;
      diag_fault = 1'b0;
      sys_rst = 1'b1;
      settle(4);
      sys_rst = 1'b0;
   endtask
   // bounded wait for the result pulse, n counts cycles waited
   task automatic wait_written(input int lo, input int hi);
      n = 0;
      pd_seen = 1'b0;
      while (written !== 1'b1 && n < 400) begin
         @(negedge clk);
         n++;
         if (pd === 1'b1) pd_seen = 1'b1;
      end
      check(16'(n >= lo && n <= hi), 16'h0001);
   endtask
   task automatic test_startup;
      do_reset(1'b1, 1'b1, 1'b0, 2'h0);
      settle(30);
      check(16'(status), 16'h0001);
      host.pulse(0);
      settle(40);
      check(16'(status), 16'h0001);
      check(16'(phase), 16'h0000);
      settle(150);
      check(16'(status), 16'h0002);
      check(16'(pd), 16'h0001);
      $display("startup done");
   endtask
   task automatic test_write_fetch;
      bridge_code = 14'h2A5C;
      host.pulse(1);
      check(16'(phase), 16'h0003);
      check(16'(status), 16'h0002);
      wait_written(19, 24);
      check(16'(status), 16'h0000);
      check(16'(ss_out), 16'h0001);
      check(16'(o_bridge), 16'h2A5C);
      settle(2);
      check(16'(pd), 16'h0001);
      host.pulse(2);
      check(16'(status), 16'h0002);
      check(16'(ss_out), 16'h0000);
      $display("write and fetch done");
   endtask
   task automatic test_read;
      temp_code = 11'h5A3;
      bridge_code = 14'h1234;
      host.pulse(0);
      settle(5);
      check(16'(phase), 16'h0001);
      host.pulse(2);
      check(16'(status), 16'h0002);
      settle(20);
      check(16'(phase), 16'h0002);
      settle(20);
      check(16'(phase), 16'h0003);
      wait_written(11, 16);
      check(16'(status), 16'h0000);
      check(16'(o_temp), 16'h05A3);
      host.pulse(2);
      $display("read done");
   endtask
   task automatic test_spi;
      do_reset(1'b1, 1'b0, 1'b1, 2'h0);
      settle(50);
      check(16'(status), 16'h0002);
      check(16'(ss_oe), 16'h0000);
      settle(160);
      host.pulse(1);
      settle(30);
      check(16'(phase), 16'h0000);
      host.spi_wake(100);
      settle(10);
      check(16'(phase), 16'h0000);
      host.spi_wake(850);
      wait_written(58, 68);
      check(16'(status), 16'h0000);
      host.pulse(2);
      $display("spi done");
   endtask
   task automatic test_periodic;
      do_reset(1'b0, 1'b1, 1'b1, 2'h1);
      settle(200);
      wait_written(0, 150);
      settle(1);
      wait_written(58, 63);
      check(16'(pd_seen), 16'h0001);
      host.pulse(2);
      check(16'(status), 16'h0002);
      wait_written(55, 62);
      check(16'(status), 16'h0000);
      diag_fault = 1'b1;
      settle(1);
      wait_written(55, 63);
      check(16'(status), 16'h0003);
      do_reset(1'b0, 1'b1, 1'b1, 2'h0);
      settle(200);
      wait_written(0, 150);
      settle(1);
      wait_written(47, 54);
      check(16'(pd_seen), 16'h0000);
      // longest rate puts the fewest ordinary runs between special runs
      do_reset(1'b0, 1'b1, 1'b1, 2'h3);
      settle(200);
      wait_written(0, 150);
      k = 0;
      do begin
         settle(1);
         wait_written(0, 200);
         k++;
      end while (n < 110 && k < 20);
      check(16'(k), 16'h0010);
      check(16'(n >= 117 && n <= 124), 16'h0001);
      $display("periodic done");
   endtask
   // write response per clock and integration
   task automatic test_conv_len;
      do_reset(1'b1, 1'b1, 1'b1, 2'h0);
      core_fast = 1'b0;
      settle(200);
      host.pulse(1);
      wait_written(28, 33);
      check(16'(status), 16'h0000);
      host.pulse(2);
      core_fast = 1'b1;
      long_integration = 1'b1;
      settle(2);
      host.pulse(1);
      wait_written(38, 43);
      check(16'(ss_out), 16'h0001);
      host.pulse(2);
      long_integration = 1'b0;
      $display("conversion length done");
   endtask
   task automatic tally_and_finish;
      $display("compares %0d mismatches %0d", cmp_count, num_errors);
      if (num_errors == 0 && cmp_count > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask
   initial begin
      {sys_rst, sleep_mode, i2c_sel, mem_locked, diag_fault} = 5'h1C;
      update_rate = 2'h0;
      core_fast = 1'b1;
      long_integration = 1'b0;
      bridge_code = 14'h0000;
      temp_code = 11'h000;
      test_startup;
      test_write_fetch;
      test_read;
      test_spi;
      test_conv_len;
      test_periodic;
      tally_and_finish;
   end
   // whole run is near 4500 cycles
   initial begin
      #300000;
      num_errors++;
      $display("watchdog expired");
      tally_and_finish;
   end
endmodule // mcs_sequencer_tb_top
`default_nettype wire
